/* rtl/bip_map.svh */
// Address map, field positions and reset values of the block-level
// interrupt pending logic.
// Assumes an 8-bit register address space shared with the channel blocks.
`ifndef BIP_MAP_SVH
`define BIP_MAP_SVH

// ==========================================================
// Geometry
`define BIP_NCHAN          3
`define BIP_ADDR_W         8
`define BIP_DATA_W         8

// ==========================================================
// Block-level registers
`define BIP_GATE_ADDR      8'h20
`define BIP_PEND_ADDR      8'h21
`define BIP_GATE_RESET     8'h00
`define BIP_PEND_RESET     8'h00
`define BIP_UNMAPPED_DATA  8'h00

// ==========================================================
// Source-level status registers, one per channel
`define BIP_SRC_STAT_CH0   8'h02
`define BIP_SRC_STAT_CH1   8'h0a
`define BIP_SRC_STAT_CH2   8'h12

// ==========================================================
// Field positions in both block-level registers
`define BIP_FLD_CH0        0
`define BIP_FLD_CH1        1
`define BIP_FLD_CH2        2
`define BIP_FLD_RSVD_LO    3
`define BIP_FLD_RSVD_HI    7

`endif

/* rtl/bip_pkg.sv */
// Types shared by the block-level interrupt pending logic.
// Assumes bip_map.svh is on the include path.
`default_nettype none

`include "bip_map.svh"

package bip_pkg;

   // Register access request from the serial control interface decoder
   typedef struct packed {
      logic                     rd;
      logic                     wr;
      logic [`BIP_ADDR_W-1:0]   addr;
      logic [`BIP_DATA_W-1:0]   wdata;
   } bip_req_t;

   // Registered answer to a read
   typedef struct packed {
      logic                     valid;
      logic                     hit;
      logic [`BIP_DATA_W-1:0]   rdata;
   } bip_rsp_t;

   typedef logic [`BIP_NCHAN-1:0] bip_chan_t;

endpackage

`default_nettype wire

/* rtl/bip_chan_latch.sv */
// One channel's block-level pending bit.
// Assumes srcLevel comes from logic on sys_clk and drops one cycle
// after the source-level status register is read.
`timescale 1ns/100ps
`default_nettype none

module bip_chan_latch
(
   // Clock, reset, enable
   input  wire logic   sys_clk,
   input  wire logic   srst,
   input  wire logic   ce,
   // Channel inputs
   input  wire logic   srcLevel,
   input  wire logic   gateEn,
   input  wire logic   srcRead,
   // Pending bit
   output logic        pending
);

   logic pend_q;
   logic pend_d;
   logic blank_q;

   // ==========================================================
   // Pending latch
   // Blank hides the source level for the cycle in which the source
   // block is still clearing after the read.
   always_comb
   begin
      pend_d = pend_q;
      if (srcRead)
      begin
         pend_d = 1'b0;
      end
      else if (gateEn && srcLevel && !blank_q)
      begin
         pend_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pend_q <= 1'b0;
      end
      else if (ce)
      begin
         pend_q <= pend_d;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         blank_q <= 1'b0;
      end
      else if (ce)
      begin
         blank_q <= srcRead;
      end
   end

   assign pending = pend_q;

endmodule

`default_nettype wire

/* rtl/bip_top.sv */
// Block-level interrupt gate and pending registers of a three-channel
// line interface. Reached over the register port of the serial control
// interface decoder; one sys_clk domain, synchronous reset.
// Assumes srcIrq comes from the channel blocks on sys_clk.
// Assumes each source block drops srcIrq within a cycle of the read of its
// status register; a level still high after the blank cycle sets the
// pending bit again, so no request is lost.
`timescale 1ns/100ps
`default_nettype none

`include "bip_map.svh"

module bip_top
#(
   parameter int NCHAN = `BIP_NCHAN
)
(
   // Clock, reset, enable
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire logic                 ce,
   // Register port
   input  wire bip_pkg::bip_req_t    regReq,
   output bip_pkg::bip_rsp_t         regRsp,
   // Channel source-level interrupt levels
   input  wire bip_pkg::bip_chan_t   srcIrq,
   // Block state to the rest of the device
   output bip_pkg::bip_chan_t        pendingOut,
   output bip_pkg::bip_chan_t        gateOut
);

   import bip_pkg::*;

   // ==========================================================
   // Address decode helpers
   // Source status address of a channel
   function automatic logic [`BIP_ADDR_W-1:0] srcStatAddr(input int ch);
      logic [`BIP_ADDR_W-1:0] a;
      a = `BIP_SRC_STAT_CH0;
      unique case (ch)
         0: a = `BIP_SRC_STAT_CH0;
         1: a = `BIP_SRC_STAT_CH1;
         2: a = `BIP_SRC_STAT_CH2;
         default: a = `BIP_SRC_STAT_CH0;
      endcase
      return a;
   endfunction

   // Read strobe at one address
   function automatic logic isRead(input bip_req_t r,
                                   input logic [`BIP_ADDR_W-1:0] a);
      return r.rd && (r.addr == a);
   endfunction

   // Write strobe at one address
   function automatic logic isWrite(input bip_req_t r,
                                    input logic [`BIP_ADDR_W-1:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // Channel bits placed in a status byte
   function automatic logic [`BIP_DATA_W-1:0] packChan(input bip_chan_t c);
      logic [`BIP_DATA_W-1:0] v;
      v = `BIP_UNMAPPED_DATA;
      v[`BIP_FLD_CH0] = c[0];
      v[`BIP_FLD_CH1] = c[1];
      v[`BIP_FLD_CH2] = c[2];
      return v;
   endfunction

   // ==========================================================
   // Register decode, shared by the gate and the read answer
   // Writes to the status register and to unmapped addresses are ignored
   logic gateWr;
   logic gateRd;
   logic pendRd;

   always_comb
   begin
      gateWr = isWrite(regReq, `BIP_GATE_ADDR);
      gateRd = isRead(regReq, `BIP_GATE_ADDR);
      pendRd = isRead(regReq, `BIP_PEND_ADDR);
   end

   // ==========================================================
   // Gate register; only bits 2 to 0 are stored, reserved write bits drop
   bip_chan_t gate_q;
   bip_chan_t gate_d;

   always_comb
   begin
      gate_d = gate_q;
      if (gateWr)
      begin
         gate_d[0] = regReq.wdata[`BIP_FLD_CH0];
         gate_d[1] = regReq.wdata[`BIP_FLD_CH1];
         gate_d[2] = regReq.wdata[`BIP_FLD_CH2];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         gate_q <= bip_chan_t'(`BIP_GATE_RESET);
      end
      else if (ce)
      begin
         gate_q <= gate_d;
      end
   end

   // ==========================================================
   // Per-channel pending latches
   // A source read beats a set in the same cycle, since the source level
   // still shows the request that is being read out.
   bip_chan_t pend;
   bip_chan_t srcRd;

   genvar g;
   generate
      for (g = 0; g < NCHAN; g++)
      begin : gChan
         assign srcRd[g] = isRead(regReq, srcStatAddr(g));

         bip_chan_latch uLatch
         (
            .sys_clk  (sys_clk),
            .srst     (srst),
            .ce       (ce),
            .srcLevel (srcIrq[g]),
            .gateEn   (gate_q[g]),
            .srcRead  (srcRd[g]),
            .pending  (pend[g])
         );
      end
   endgenerate

   // ==========================================================
   // Pending status value; channel bits in place, reserved bits zero
   // The word is built from the latches, never from the pipelined copy
   logic [`BIP_DATA_W-1:0] pendWord;

   always_comb
   begin
      pendWord = `BIP_PEND_RESET;
      pendWord[`BIP_FLD_CH2] = pend[2];
      pendWord[`BIP_FLD_CH1] = pend[1];
      pendWord[`BIP_FLD_CH0] = pend[0];
   end

   // ==========================================================
   // Read answer, one cycle after the request
   // Unmapped reads still answer, with hit low and zero data, so that a
   // device-level mux can merge the answers of all blocks.
   bip_rsp_t rsp_q;
   bip_rsp_t rsp_d;

   always_comb
   begin
      rsp_d = '0;
      rsp_d.rdata = `BIP_UNMAPPED_DATA;
      if (regReq.rd)
      begin
         rsp_d.valid = 1'b1;
         if (pendRd)
         begin
            rsp_d.hit   = 1'b1;
            rsp_d.rdata = pendWord;
         end
         else if (gateRd)
         begin
            rsp_d.hit   = 1'b1;
            rsp_d.rdata = packChan(gate_q);
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rsp_q <= '0;
      end
      else if (ce)
      begin
         rsp_q <= rsp_d;
      end
   end

   // ==========================================================
   // Registered state outputs
   // The copy of the pending bits lags the status register by one cycle;
   // gateOut comes straight from the gate register.
   bip_chan_t pendOut_q;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pendOut_q <= '0;
      end
      else if (ce)
      begin
         pendOut_q <= pend;
      end
   end

   assign regRsp     = rsp_q;
   assign pendingOut = pendOut_q;
   assign gateOut    = gate_q;

endmodule

`default_nettype wire

/* verification/bip_monitor.sv */
// Port checker of bip_top, bound into every instance.
// Assumes reset held at least two cycles; helpers age only while ce is high.
`timescale 1ns/100ps
`default_nettype none
module bip_monitor
(
   // Clock and reset
   input wire logic               sys_clk,
   input wire logic               srst,
   input wire logic               ce,
   // Watched ports
   input wire bip_pkg::bip_req_t  regReq,
   input wire bip_pkg::bip_rsp_t  regRsp,
   input wire bip_pkg::bip_chan_t srcIrq,
   input wire bip_pkg::bip_chan_t pendingOut,
   input wire bip_pkg::bip_chan_t gateOut
);
   import bip_pkg::*;
   bip_chan_t srcRd, rdQ, rdQQ, setQ, setQQ, whyQ, whyQQ;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ==========================================================
   // Source status reads, causes and set conditions, aged two cycles
   assign srcRd = {3{ce & regReq.rd}} & {regReq.addr == 8'h12,
      regReq.addr == 8'h0a, regReq.addr == 8'h02};
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rdQ   <= '0;
         rdQQ  <= '0;
         whyQ  <= '0;
         whyQQ <= '0;
         setQ  <= '0;
         setQQ <= '0;
      end
      else if (ce)
      begin
         rdQ   <= srcRd;
         rdQQ  <= rdQ;
         whyQ  <= gateOut & srcIrq;
         whyQQ <= whyQ;
         setQ  <= gateOut & srcIrq & ~srcRd & ~rdQ;
         setQQ <= setQ;
      end
   end
   // ==========================================================
   // Assertions
   AST_RSVD_ZERO: assert property (regRsp.valid |->
      regRsp.rdata[7:3] == 5'h00) else $error("upper bits set");
   AST_RESET_CLEAR: assert property ($past(srst) |->
      pendingOut == 3'h0 && gateOut == 3'h0 && regRsp == '0)
      else $error("reset left state");
   AST_PEND_READ: assert property ($past(regReq.rd) &&
      $past(ce) && $past(regReq.addr) == 8'h21 |-> regRsp.valid &&
      regRsp.hit && regRsp.rdata[2:0] == pendingOut)
      else $error("status read wrong");
   AST_HOLD: assert property (
      ($past(pendingOut) & ~pendingOut & ~rdQQ) == 3'h0)
      else $error("pending dropped without source read");
   AST_GATED: assert property (
      (pendingOut & ~$past(pendingOut) & ~whyQQ) == 3'h0)
      else $error("pending rose without enabled cause");
   AST_SET: assert property ((pendingOut & setQQ) == setQQ)
      else $error("enabled source not flagged");
   AST_GATE_WR: assert property (ce && regReq.wr &&
      regReq.addr == 8'h20 |=> gateOut == $past(regReq.wdata[2:0]))
      else $error("gate write lost");
   AST_FREEZE: assert property (!$past(ce) && !$past(srst) |->
      $stable(pendingOut) && $stable(gateOut) && $stable(regRsp))
      else $error("state moved while clock enable low");
endmodule
bind bip_top bip_monitor i_bip_monitor (.sys_clk, .srst, .ce, .regReq,
   .regRsp, .srcIrq, .pendingOut, .gateOut);
`default_nettype wire

/* verification/bip_top_bench.sv */
// Self-checking bench of bip_top: directed and random traffic
// against a reference model. ce drops at random to check the freeze.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("BAD t=%0t got %h want %h", $time, a, b); end end
module bip_top_bench;
   import bip_pkg::*;
   logic      sys_clk = 1'b0, srst = 1'b1, ce = 1'b1;
   bip_req_t  regReq = '0;
   bip_rsp_t  regRsp, mRsp;
   bip_chan_t srcIrq = '0, pendingOut, gateOut, mPend, mGate, mOut, mBlank, rdv;
   int        err_total = 0, total_checks = 0;
   logic [15:0] lf = 16'h7f5b;
   logic [7:0]  adr [8] = '{8'h02, 8'h0a, 8'h12, 8'h20, 8'h21, 8'h21,
      8'h00, 8'h35};
   always #2.5 sys_clk = ~sys_clk;
   bip_top i_bip_top (.sys_clk, .srst, .ce, .regReq, .regRsp, .srcIrq,
      .pendingOut, .gateOut);
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic bip_rsp_t exp_rsp(input bip_req_t q,
      input bip_chan_t p, input bip_chan_t g);
      logic [7:0] d;
      d = q.addr == 8'h21 ? {5'h00, p} : q.addr == 8'h20 ? {5'h00, g} : 8'h00;
      return q.rd ? {1'b1, q.addr[7:1] == 7'h10, d} : '0;
   endfunction
   // ==========================================================
   // Reference model; clear wins over set, then one blank cycle;
   // everything but reset is frozen while ce is low
   always @(posedge sys_clk)
   begin
      if (srst | ce)
      begin
         rdv = {3{regReq.rd}} & {regReq.addr == 8'h12,
            regReq.addr == 8'h0a, regReq.addr == 8'h02};
         mRsp   <= srst ? '0 : exp_rsp(regReq, mPend, mGate);
         mOut   <= srst ? '0 : mPend;
         mPend  <= srst ? '0 : (mPend | mGate & srcIrq & ~mBlank) & ~rdv;
         mBlank <= srst ? '0 : rdv;
         if (srst | regReq.wr & regReq.addr == 8'h20)
            mGate <= srst ? '0 : regReq.wdata[2:0];
      end
   end
   always @(negedge sys_clk)
      if (!srst)
      begin
         `CHK(regRsp, mRsp)
         `CHK(pendingOut, mOut)
         `CHK(gateOut, mGate)
      end
   task cyc(input bip_req_t q, input bip_chan_t s);
      @(posedge sys_clk);
      regReq <= q;
      srcIrq <= s;
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // Directed corners, mid-run reset, then random traffic
   initial
   begin
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      cyc({2'b10, 8'h20, 8'h00}, 3'h7);
      repeat (3) cyc({2'b10, 8'h21, 8'h00}, 3'h7);
      cyc({2'b01, 8'h20, 8'hff}, 3'h0);
      cyc({2'b10, 8'h21, 8'h00}, 3'h5);
      repeat (4) cyc({2'b10, 8'h21, 8'h00}, 3'h0);
      cyc({2'b10, 8'h02, 8'h00}, 3'h1);
      cyc({2'b10, 8'h21, 8'h00}, 3'h1);
      cyc({2'b10, 8'h21, 8'h00}, 3'h0);
      cyc({2'b01, 8'h20, 8'h00}, 3'h0);
      cyc({2'b10, 8'h12, 8'h00}, 3'h0);
      repeat (3) cyc({2'b10, 8'h21, 8'h00}, 3'h7);
      srst <= 1'b1;
      repeat (3) cyc('0, 3'h0);
      srst <= 1'b0;
      repeat (3000)
      begin
         lf = lfsr(lf);
         cyc({lf[0], ~lf[0] & lf[1], adr[lf[4:2]], lf[15:8]},
            lf[7:5] & lf[13:11]);
         ce <= lf[14] | lf[9];
      end
      repeat (3) @(posedge sys_clk);
      final_report();
   end
endmodule
`default_nettype wire
